// ### logic/cop_top.sv
`default_nettype none

`include "cop_params.svh"

module cop_top #(
  parameter logic [`COP_DEG_W-1:0]  DEG1_CYC =
    `COP_DEG_W'(`COP_DEG1_US * `COP_CLK_MHZ),
  parameter logic [`COP_DEG_W-1:0]  DEG2_CYC =
    `COP_DEG_W'(`COP_DEG2_US * `COP_CLK_MHZ),
  parameter logic [`COP_DEG_W-1:0]  DEG3_CYC =
    `COP_DEG_W'(`COP_DEG3_US * `COP_CLK_MHZ),
  parameter logic [`COP_SHIP_W-1:0] SHIP_CYC =
    `COP_SHIP_W'(`COP_SHIP_US * `COP_CLK_MHZ),
  parameter logic [`COP_WAKE_W-1:0] WAKE_CYC =
    `COP_WAKE_W'(64'(`COP_WAKE_S) * 64'(`COP_US_PER_S) * 64'(`COP_CLK_MHZ))
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              en_i,
  input  wire cop_pkg::cop_req_t req_i,
  input  wire logic              cmp_above_i,
  input  wire logic              battery_below_min_i,
  input  wire logic              srn_at_zero_i,
  input  wire logic              charge_current_write_i,
  output var  cop_pkg::cop_rsp_t rsp_o,
  output logic                   comparator_threshold_select_o,
  output logic                   comparator_output_pin_o,
  output logic                   high_impedance_state_o,
  output logic                   charger_good_signal_o,
  output logic                   charge_force_zero_o,
  output logic                   pass_through_mode_o,
  output logic                   ship_discharge_sink_o,
  output logic                   auto_wakeup_charge_o
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam logic [`COP_DEG_W-1:0] DEG0_CYC =
    `COP_DEG_W'(`COP_DEG0_US * `COP_CLK_MHZ);

  localparam logic [`COP_SHIP_W-1:0] SHIP_ONE = `COP_SHIP_W'(1);
  localparam logic [`COP_WAKE_W-1:0] WAKE_ONE = `COP_WAKE_W'(1);

  // reset image: registers at their defaults, pins idle
  localparam cop_pkg::cop_state_t RST_STATE = '{
    opt1:    `COP_OPT1_RST,
    opt2:    `COP_OPT2_RST,
    chg_ok:  1'b1,
    comparator_output_pin:  1'b1,
    default: '0
  };

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cop_pkg::cop_state_t st_q;
  cop_pkg::cop_state_t st_d;

  logic                  above;
  logic                  batt_low;
  logic                  srn_zero;
  logic                  trip;
  logic                  filt;
  logic [`COP_DEG_W-1:0] deg_limit;
  logic                  wr_opt1;
  logic                  wr_opt2;
  logic                  rel_now;
  logic                  ref_bit;
  logic                  pol_bit;
  logic [1:0]            deg_code;
  logic                  stop_bit;
  logic                  ptm_bit;
  logic                  ship_bit;
  logic                  wake_bit;

  // synchronised pin levels, read only from the second stage
  assign above    = st_q.sy_cmp[1];
  assign batt_low = st_q.sy_low[1];
  assign srn_zero = st_q.sy_srn[1];

  // host write decode
  assign wr_opt1 = req_i.wr && (req_i.cmd == `COP_CMD_OPT1);
  assign wr_opt2 = req_i.wr && (req_i.cmd == `COP_CMD_OPT2);

  // ----------------------------------------------------------------
  // option one low byte fields
  // ----------------------------------------------------------------
  // stored control bits, named once for the logic below
  assign ref_bit  = st_q.opt1[`COP_B_REF];
  assign pol_bit  = st_q.opt1[`COP_B_POL];
  assign deg_code = st_q.opt1[`COP_B_DEG_HI:`COP_B_DEG_LO];
  assign stop_bit = st_q.opt1[`COP_B_FOFF];
  assign ptm_bit  = st_q.opt1[`COP_B_PTM];
  assign ship_bit = st_q.opt1[`COP_B_SHIP];
  assign wake_bit = st_q.opt1[`COP_B_WAKE];

  // ----------------------------------------------------------------
  // comparator path
  // ----------------------------------------------------------------
  // trip sense depends on output polarity
  assign trip = pol_bit ? ~above : above;

  // filter time per code; the comparator runs in every code
  always_comb begin
    case (deg_code)
      `COP_DEG_5US:  deg_limit = DEG0_CYC;
      `COP_DEG_2MS:  deg_limit = DEG1_CYC;
      `COP_DEG_20MS: deg_limit = DEG2_CYC;
      `COP_DEG_5S:   deg_limit = DEG3_CYC;
      default:       deg_limit = DEG0_CYC;
    endcase
  end

  // falling-edge filter of the comparator output
  cop_deglitch u_deg (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .en_i    (en_i),
    .trip_i  (trip),
    .limit_i (deg_limit),
    .filt_o  (filt)
  );

  // released counts the current cycle as well
  assign rel_now = st_q.rel | ~filt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // two-stage synchronisers for pin inputs
    st_d.sy_cmp = {st_q.sy_cmp[0], cmp_above_i};
    st_d.sy_low = {st_q.sy_low[0], battery_below_min_i};
    st_d.sy_srn = {st_q.sy_srn[0], srn_at_zero_i};

    // ------------------------------------------------------------
    // comparator output pin
    // ------------------------------------------------------------
    // output pin low while filtered trip stands
    st_d.comparator_output_pin = ~filt;

    // ------------------------------------------------------------
    // high impedance latch
    // ------------------------------------------------------------
    // the latch needs the stop bit; without it a trip only moves the pin
    // high impedance latch on trip with stop bit set
    if (stop_bit && filt && !st_q.high_impedance_state) begin
      st_d.high_impedance_state = 1'b1;
      st_d.rel = 1'b0;
    end else if (st_q.high_impedance_state) begin
      st_d.rel = rel_now;
      if (filt) begin
        st_d.rel = 1'b0;
      end
    end

    // ------------------------------------------------------------
    // pass-through request
    // ------------------------------------------------------------
    // pass-through request bit returns to zero by itself
    if (ptm_bit) begin
      st_d.opt1[`COP_B_PTM] = 1'b0;
    end

    // ------------------------------------------------------------
    // ship discharge
    // ------------------------------------------------------------
    // srn_done keeps the sink off so the pin is not pulled below zero
    // ship discharge interval countdown
    if (ship_bit) begin
      if (st_q.ship_cnt <= SHIP_ONE) begin
        st_d.opt1[`COP_B_SHIP] = 1'b0;
        st_d.ship_cnt          = '0;
      end else begin
        st_d.ship_cnt = st_q.ship_cnt - SHIP_ONE;
      end
      if (srn_zero) begin
        st_d.srn_done = 1'b1;
      end
    end

    // ------------------------------------------------------------
    // auto wakeup charge
    // ------------------------------------------------------------
    // auto wakeup charge timing and exits
    if (st_q.wake_chg) begin
      if (st_q.wake_cnt >= WAKE_CYC - WAKE_ONE) begin
        st_d.opt1[`COP_B_WAKE] = 1'b0;
      end else begin
        st_d.wake_cnt = st_q.wake_cnt + WAKE_ONE;
      end
      if (!batt_low) begin
        st_d.opt1[`COP_B_WAKE] = 1'b0;
      end
    end
    if (charge_current_write_i) begin
      st_d.opt1[`COP_B_WAKE] = 1'b0;
    end

    // ------------------------------------------------------------
    // host writes
    // ------------------------------------------------------------
    // a write also restarts the ship interval or stops it at once
    // host writes come last so they win over hardware clears
    if (wr_opt1) begin
      st_d.opt1 = req_i.wdata;
      st_d.pass_through_mode  = req_i.wdata[`COP_B_PTM];
      if (req_i.wdata[`COP_B_SHIP]) begin
        st_d.ship_cnt = SHIP_CYC;
        st_d.srn_done = 1'b0;
      end else begin
        st_d.ship_cnt = '0;
        st_d.srn_done = 1'b0;
      end
      if (req_i.wdata[`COP_B_WAKE] && !wake_bit) begin
        st_d.wake_cnt = '0;
      end
      // exit only once output is back high, then the bit cleared
      if (st_q.high_impedance_state && rel_now && !req_i.wdata[`COP_B_FOFF]) begin
        st_d.high_impedance_state = 1'b0;
        st_d.rel = 1'b0;
      end
    end
    if (wr_opt2) begin
      st_d.opt2 = req_i.wdata;
    end

    // counter restarts whenever the wakeup bit is off
    if (!st_d.opt1[`COP_B_WAKE]) begin
      st_d.wake_cnt = '0;
    end

    // ------------------------------------------------------------
    // derived pin drives
    // ------------------------------------------------------------
    // computed from st_d so pins move in the same edge as the bits
    // derived pin drives
    st_d.chg_ok   = ~st_d.high_impedance_state;
    st_d.sink     = st_d.opt1[`COP_B_SHIP] & ~st_d.srn_done;
    st_d.wake_chg = st_d.opt1[`COP_B_WAKE] & batt_low;

    // ------------------------------------------------------------
    // read answer
    // ------------------------------------------------------------
    // read answer, one cycle after the request
    st_d.rsp.rvalid = req_i.rd;
    st_d.rsp.rdata  = '0;
    if (req_i.rd) begin
      case (req_i.cmd)
        `COP_CMD_OPT1: st_d.rsp.rdata = st_q.opt1;
        `COP_CMD_OPT2: st_d.rsp.rdata = st_q.opt2;
        default:       st_d.rsp.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // defaults at power-on, frozen while enable is low
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= RST_STATE;
    end else if (en_i) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // all straight from state flops
  assign rsp_o                         = st_q.rsp;
  assign comparator_threshold_select_o = ref_bit;
  assign comparator_output_pin_o       = st_q.comparator_output_pin;
  assign high_impedance_state_o        = st_q.high_impedance_state;
  assign charger_good_signal_o         = st_q.chg_ok;
  assign charge_force_zero_o           = st_q.high_impedance_state;
  assign pass_through_mode_o           = st_q.pass_through_mode;
  assign ship_discharge_sink_o         = st_q.sink;
  assign auto_wakeup_charge_o          = st_q.wake_chg;

endmodule : cop_top

`default_nettype wire

// ### logic/cop_params.svh
`ifndef COP_PARAMS_SVH
`define COP_PARAMS_SVH

// ----------------------------------------------------------------
// command codes and reset values
// ----------------------------------------------------------------
`define COP_CMD_OPT1      8'h30
`define COP_CMD_OPT2      8'h31
`define COP_OPT1_RST      16'h3300
`define COP_OPT2_RST      16'h00B7

// ----------------------------------------------------------------
// low byte field positions of option one
// ----------------------------------------------------------------
`define COP_B_WAKE        0
`define COP_B_SHIP        1
`define COP_B_PTM         2
`define COP_B_FOFF        3
`define COP_B_DEG_LO      4
`define COP_B_DEG_HI      5
`define COP_B_POL         6
`define COP_B_REF         7

// falling filter codes
`define COP_DEG_5US       2'h0
`define COP_DEG_2MS       2'h1
`define COP_DEG_20MS      2'h2
`define COP_DEG_5S        2'h3

// ----------------------------------------------------------------
// timing, in printed units, and counter widths
// ----------------------------------------------------------------
`define COP_CLK_MHZ       50
`define COP_DEG0_US       5
`define COP_DEG1_US       2000
`define COP_DEG2_US       20000
`define COP_DEG3_US       5000000
`define COP_SHIP_US       140000
`define COP_WAKE_S        1800
`define COP_US_PER_S      1000000
`define COP_DEG_W         28
`define COP_SHIP_W        23
`define COP_WAKE_W        37

`endif

// ### logic/cop_pkg.sv
`default_nettype none

`include "cop_params.svh"

package cop_pkg;

  // ----------------------------------------------------------------
  // host command port
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  cmd;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } cop_req_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic        rvalid;
  } cop_rsp_t;

  // ----------------------------------------------------------------
  // state of the falling filter
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`COP_DEG_W-1:0] cnt;
    logic                  filt;
  } cop_deg_state_t;

  // ----------------------------------------------------------------
  // state of the option control block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]            opt1;
    logic [15:0]            opt2;
    logic [1:0]             sy_cmp;
    logic [1:0]             sy_low;
    logic [1:0]             sy_srn;
    logic                   high_impedance_state;
    logic                   rel;
    logic                   chg_ok;
    logic                   comparator_output_pin;
    logic                   pass_through_mode;
    logic [`COP_SHIP_W-1:0] ship_cnt;
    logic                   srn_done;
    logic                   sink;
    logic [`COP_WAKE_W-1:0] wake_cnt;
    logic                   wake_chg;
    cop_rsp_t               rsp;
  } cop_state_t;

endpackage : cop_pkg

`default_nettype wire

// ### logic/cop_deglitch.sv
`default_nettype none

`include "cop_params.svh"

module cop_deglitch (
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  en_i,
  input  wire logic                  trip_i,
  input  wire logic [`COP_DEG_W-1:0] limit_i,
  output logic                       filt_o
);

  cop_pkg::cop_deg_state_t st_q;
  cop_pkg::cop_deg_state_t st_d;

  // trip must hold limit cycles before it shows; release is at once
  always_comb begin
    st_d = st_q;
    if (!trip_i) begin
      st_d.filt = 1'b0;
      st_d.cnt  = '0;
    end else if (!st_q.filt) begin
      if (st_q.cnt >= limit_i - `COP_DEG_W'(1)) begin
        st_d.filt = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + `COP_DEG_W'(1);
      end
    end
  end

  // state register, frozen while enable is low
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= '0;
    end else if (en_i) begin
      st_q <= st_d;
    end
  end

  assign filt_o = st_q.filt;

endmodule : cop_deglitch

`default_nettype wire

// ### verif/cop_top_asserts.sv
`default_nettype none

`include "cop_params.svh"

module cop_top_asserts #(
  parameter logic [`COP_SHIP_W-1:0] SHIP_CYC = 20
) (
  input wire logic              clk_i,
  input wire logic              rstn_i,
  input wire logic              en_i,
  input wire cop_pkg::cop_req_t req_i,
  input wire cop_pkg::cop_rsp_t rsp_o,
  input wire logic              comparator_threshold_select_o,
  input wire logic              comparator_output_pin_o,
  input wire logic              high_impedance_state_o,
  input wire logic              charger_good_signal_o,
  input wire logic              charge_force_zero_o,
  input wire logic              pass_through_mode_o,
  input wire logic              ship_discharge_sink_o,
  input wire logic              auto_wakeup_charge_o,
  input wire logic              charge_current_write_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  logic        wr1;
  logic [31:0] ship_n_q;

  // option one write taken at this edge
  assign wr1 = en_i && req_i.wr && req_i.cmd == `COP_CMD_OPT1;

  // cycles the sink has stood since its last start
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) ship_n_q <= 32'h0;
    else if (!ship_discharge_sink_o || (wr1 && req_i.wdata[1])) ship_n_q <= 32'h0;
    else if (en_i) ship_n_q <= ship_n_q + 32'h1;
  end

  sequence s_rd_alone;
    en_i && req_i.rd ##1 en_i && !req_i.rd;
  endsequence
  sequence s_one_pulse;
    rsp_o.rvalid ##1 !rsp_o.rvalid;
  endsequence

  a_read_pulse: assert property (s_rd_alone |-> s_one_pulse)
    else $error("read answer not one pulse");
  a_good_tracks: assert property (charger_good_signal_o == !high_impedance_state_o)
    else $error("charger good not inverse of latch");
  a_zero_tracks: assert property (charge_force_zero_o == high_impedance_state_o)
    else $error("current force not equal to latch");
  a_hiz_entry: assert property ($rose(high_impedance_state_o) |->
    $fell(comparator_output_pin_o)) else $error("latch set without trip");
  a_hiz_hold: assert property (high_impedance_state_o && !comparator_output_pin_o &&
    !wr1 |=> high_impedance_state_o) else $error("latch left while tripped");
  a_ref_follow: assert property (wr1 |=>
    comparator_threshold_select_o == $past(req_i.wdata[7])) else $error("ref select");
  a_ptm_follow: assert property (wr1 |=>
    pass_through_mode_o == $past(req_i.wdata[2])) else $error("pass-through mode");
  a_ship_start: assert property (wr1 && req_i.wdata[1] |=> ship_discharge_sink_o)
    else $error("sink not started");
  a_ship_stop: assert property (wr1 && !req_i.wdata[1] |=> !ship_discharge_sink_o)
    else $error("sink not stopped");
  a_ship_bound: assert property (ship_n_q <= {9'h0, SHIP_CYC} + 32'h2)
    else $error("sink outlived interval");
  a_wake_exit: assert property (en_i && charge_current_write_i && !wr1 |=>
    !auto_wakeup_charge_o) else $error("wakeup kept after current write");
endmodule : cop_top_asserts

bind cop_top cop_top_asserts #(.SHIP_CYC(SHIP_CYC)) u_asserts (
  .clk_i(clk_i), .rstn_i(rstn_i), .en_i(en_i), .req_i(req_i), .rsp_o(rsp_o),
  .comparator_threshold_select_o(comparator_threshold_select_o),
  .comparator_output_pin_o(comparator_output_pin_o),
  .high_impedance_state_o(high_impedance_state_o),
  .charger_good_signal_o(charger_good_signal_o), .charge_force_zero_o(charge_force_zero_o),
  .pass_through_mode_o(pass_through_mode_o), .ship_discharge_sink_o(ship_discharge_sink_o),
  .auto_wakeup_charge_o(auto_wakeup_charge_o),
  .charge_current_write_i(charge_current_write_i)
);

`default_nettype wire

// ### verif/cop_host.sv
`default_nettype none

module cop_host (
  input  wire logic              clk_i,
  input  wire cop_pkg::cop_rsp_t rsp_i,
  output var  cop_pkg::cop_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // bus idle until the first request
  initial req_o = '0;

  // one word write, strobe held over one taking edge
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_i);
    #1 req_o = '{c, 1'b1, 1'b0, d};
    @(posedge clk_i);
    #1 req_o.wr = 1'b0;
  endtask : wr

  // one word read, answer taken once the taking edge has landed
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(posedge clk_i);
    #1 req_o = '{c, 1'b0, 1'b1, 16'h0000};
    @(posedge clk_i);
    #1 req_o.rd = 1'b0;
    d = rsp_i.rvalid ? rsp_i.rdata : 16'hXXXX;
  endtask : rd
endmodule : cop_host

`default_nettype wire

// ### verif/charge_option_low_control_tb_top.sv
`default_nettype none

module charge_option_low_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int D1 = 8, D2 = 16, D3 = 32, SH = 20, WK = 40;
  logic              clk_i, rstn_i, en, cmp, blow, battery_sense_negative, ccw;
  logic              rsel, cout, high_impedance_state, good, fz, pass_through_mode, sink, wake;
  cop_pkg::cop_req_t req;
  cop_pkg::cop_rsp_t rsp;
  int                n_errors = 0, n_tests = 0, cyc = 0, n, m1, m2;
  int                deg[4] = '{250, D1, D2, D3};
  logic [7:0]        r = 8'h1A;
  logic [15:0]       d;
  logic [15:0]       exp_q[$];

  cop_host h (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));
  cop_top #(
    .DEG1_CYC(28'(D1)), .DEG2_CYC(28'(D2)), .DEG3_CYC(28'(D3)),
    .SHIP_CYC(23'(SH)), .WAKE_CYC(37'(WK))
  ) i_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .en_i(en), .req_i(req), .cmp_above_i(cmp),
    .battery_below_min_i(blow), .srn_at_zero_i(battery_sense_negative), .charge_current_write_i(ccw),
    .rsp_o(rsp), .comparator_threshold_select_o(rsel), .comparator_output_pin_o(cout),
    .high_impedance_state_o(high_impedance_state), .charger_good_signal_o(good), .charge_force_zero_o(fz),
    .pass_through_mode_o(pass_through_mode), .ship_discharge_sink_o(sink), .auto_wakeup_charge_o(wake));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic g, input logic e);
    chk_reg({15'h0, g}, {15'h0, e});
  endtask : chk_pin

  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    h.rd(c, d);
    chk_reg(d, exp_q.pop_front());
  endtask : rdc

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  // free-running clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    {cmp, blow, battery_sense_negative, ccw, rstn_i} = '0;
    en = 1'b1;
    m1 = 32'h0000_3300;
    m2 = 32'h0000_00B7;
    tick(2);
    rstn_i = 1'b1;
    rdc(8'h30, m1[15:0]); // full default
    rdc(8'h31, m2[15:0]); // default
    rdc(8'h32, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      m2 = {r, ~r};
      m1 = {r, r[7:6], 6'h00};
      h.wr(8'h31, m2[15:0]);
      h.wr(8'h30, m1[15:0]);
      chk_pin(rsel, r[7]); // reference select
      rdc(8'h31, m2[15:0]); // storage
      rdc(8'h30, m1[15:0]); // low byte fields
    end
    $display("register test done");
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        cmp = p[0];
        h.wr(8'h30, 16'(p * 64 + c * 16));
        tick(3);
        cmp = !p[0];
        n = 0;
        while (cout === 1'b1 && n < 400) begin
          tick(1);
          n++;
        end
        chk_pin(n >= deg[c] && n <= deg[c] + 6, 1'b1); // filter time
        chk_pin(high_impedance_state, 1'b0); // no latch
        cmp = p[0];
        tick(5);
        chk_pin(cout, 1'b1); // quick release
      end
    end
    $display("comparator test done");
    cmp = 1'b0;
    h.wr(8'h30, 16'h0018);
    cmp = 1'b1;
    tick(16);
    chk_reg({high_impedance_state, good, fz}, 3'b101); // latched off
    h.wr(8'h30, 16'h0010);
    cmp = 1'b0;
    tick(6);
    chk_pin(high_impedance_state, 1'b1); // early clear ignored
    h.wr(8'h30, 16'h0018);
    h.wr(8'h30, 16'h0010);
    tick(1);
    chk_reg({high_impedance_state, good, fz}, 3'b010); // release then clear
    $display("latch test done");
    h.wr(8'h30, 16'h0004);
    chk_pin(pass_through_mode, 1'b1); // mode on
    rdc(8'h30, 16'h0000); // bit self clears
    h.wr(8'h30, 16'h0000);
    chk_pin(pass_through_mode, 1'b0); // mode off
    $display("pass-through test done");
    h.wr(8'h30, 16'h0002);
    tick(SH - 4);
    chk_pin(sink, 1'b1); // sinking
    tick(6);
    chk_pin(sink, 1'b0); // interval over
    rdc(8'h30, 16'h0000); // bit cleared
    h.wr(8'h30, 16'h0002);
    h.wr(8'h30, 16'h0000);
    chk_pin(sink, 1'b0); // host stop
    h.wr(8'h30, 16'h0002);
    battery_sense_negative = 1'b1;
    tick(4);
    chk_pin(sink, 1'b0); // pin at zero
    rdc(8'h30, 16'h0002); // bit still set
    battery_sense_negative = 1'b0;
    tick(SH);
    h.wr(8'h30, 16'h0002); // second interval
    chk_pin(sink, 1'b1); // restarted
    h.wr(8'h30, 16'h0000);
    $display("ship test done");
    blow = 1'b1;
    tick(3);
    h.wr(8'h30, 16'h0001);
    tick(1);
    chk_pin(wake, 1'b1); // wakeup charge
    blow = 1'b0;
    tick(4);
    chk_pin(wake, 1'b0); // battery recovered
    rdc(8'h30, 16'h0000); // bit cleared
    blow = 1'b1;
    tick(3);
    h.wr(8'h30, 16'h0001);
    ccw = 1'b1;
    tick(1);
    ccw = 1'b0;
    tick(1);
    chk_pin(wake, 1'b0); // current write
    rdc(8'h30, 16'h0000); // bit cleared
    h.wr(8'h30, 16'h0001);
    tick(WK - 10);
    chk_pin(wake, 1'b1); // still charging
    tick(14);
    chk_pin(wake, 1'b0); // time limit
    $display("wakeup test done");
    h.wr(8'h30, 16'h0002);
    en = 1'b0;
    tick(SH + 4);
    chk_pin(sink, 1'b1); // interval frozen by enable
    en = 1'b1;
    tick(SH + 2);
    chk_pin(sink, 1'b0); // interval resumes and ends
    $display("enable test done");
    finish_test();
  end
endmodule : charge_option_low_control_tb_top

`default_nettype wire
